// >>> rtl/vector_map_pkg.sv
/*
 * Constants of the interrupt vector map: per-source vector numbers,
 * table addresses, flag and priority positions, reset values.
 * Assumes a single system clock and an active-low asynchronous reset.
 */
// Overview of operation
// RULE1: reset clears registers; program counter forced to zero, fetch from 0x000000.
// RULE2: reset is no exception; controller does no vector fetch or arbitration.
// RULE3: firmware fills unused table entries with a default reset handler.
// RULE4: external request zero: vector 8, request 0, address 0x000014.
// RULE5: capture unit one: vector 9, address 0x000016, bit 1, priority 6:4.
// RULE6: compare unit one: vector 10, address 0x000018, bit 2.
// RULE7: dma channel zero: vector 12, request 4, address 0x00001C.
// RULE8: serial one done: vector 18, request 10, address 0x000028.
// RULE9: uart one receive: vector 19, address 0x00002A, bit 11.
// RULE10: converter done: vector 21, address 0x00002E, bit 13.
// RULE11: i2c one target: vector 24, request 16; sixteen requests per register.
// RULE12: input change: vector 27, address 0x00003A, register 1 bit 3.
// RULE13: dma channel two: vector 32, request 24, address 0x000044.
// RULE14: uart two transmit: vector 39, request 31, address 0x000052.
// RULE15: can receive ready: vector 42, address 0x000058, register 2 bit 2.
// RULE16: i2c two target: vector 57, request 49, address 0x000076.
// RULE17: pwm special match: vector 65, address 0x000086, register 3 bit 9.
// RULE18: uart one error: vector 73, request 65, address 0x000096.
// RULE19: crc generator: vector 75, address 0x00009A, register 4 bit 3.
// RULE20: charge time unit: vector 85, address 0x0000AE, flag register 5 bit 13.
// RULE21: pwm generator one: vector 102, address 0x0000D0, register 5 bit 14.
// RULE22: trigger watchdog: vector 154, request 146, address 0x000138.
// RULE23: vector table starts at 000004h; entries hold 24-bit handler addresses.
// RULE24: equal priority ties go to lower vector number.
// RULE25: flags set by peripheral, stay set until software clears them.
// RULE26: every source has a three-bit priority field, eight levels.
// RULE27: reserved vectors have no storage and never raise a request.
// RULE28: request core only when flag, enable set and priority exceeds core level.
// RULE29: present winning vector number and priority with the request.
package vector_map_pkg;
    localparam int NUM_SOURCES = 19;
    localparam int VEC_W = 8;
    localparam int IRQ_W = 8;
    localparam int PRIO_W = 3;
    localparam int ADDR_W = 24;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h000000;
    localparam logic [ADDR_W-1:0] TABLE_BASE = 24'h000004;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam int VEC_TO_IRQ = 8;
    // table entries are two words apart, user sources start at vector 8
    localparam int VEC_STRIDE = 2;
    localparam int FLAG_BITS = 16;
    // source index to vector number, ascending so index order is vector order
    localparam logic [VEC_W-1:0] SRC_VECTOR [NUM_SOURCES] = '{
        8'h08, 8'h09, 8'h0A, 8'h0C, 8'h12, 8'h13, 8'h15, 8'h18, 8'h1B,
        8'h20, 8'h27, 8'h2A, 8'h39, 8'h41, 8'h49, 8'h4B, 8'h55, 8'h66,
        8'h9A};
    // flag register number per source (charge time unit flag lives in 5)
    localparam int SRC_FLAG_REG [NUM_SOURCES] = '{
        0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 3, 4, 4, 5, 5, 9};
    // enable register number per source, as printed
    localparam int SRC_EN_REG [NUM_SOURCES] = '{
        0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 3, 4, 4, 4, 5, 9};
    localparam int SRC_BIT [NUM_SOURCES] = '{
        0, 1, 2, 4, 10, 11, 13, 0, 3, 8, 15, 2, 1, 9, 1, 3, 13, 14, 2};
    localparam int SRC_PRIO_REG [NUM_SOURCES] = '{
        0, 0, 0, 1, 2, 2, 3, 4, 4, 6, 7, 8, 12, 14, 16, 16, 19, 23, 36};
    localparam int SRC_PRIO_LSB [NUM_SOURCES] = '{
        0, 4, 8, 0, 8, 12, 4, 0, 12, 0, 12, 8, 4, 4, 4, 12, 4, 8, 8};
endpackage

// >>> rtl/interrupt_vector_map.sv
/*
 * Interrupt vector map: latches peripheral request pulses into flags,
 * gates them by enables, picks the winner by priority then vector
 * order and hands one registered request to the core.
 * Assumes request inputs synchronous to clock; software clears flags
 * through flag_clear pulses; the core supplies its current level.
 */
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_map
    import vector_map_pkg::*;
#(
    parameter int N = NUM_SOURCES
) (
    // system
    input wire logic clock,
    input wire logic reset_n,
    // peripheral side
    input wire logic [N-1:0] source_event,
    input wire logic [N-1:0] flag_clear,
    input wire logic [N-1:0] flag_set_sw,
    input wire logic [N-1:0] enable,
    input wire logic [N*PRIO_W-1:0] priority_level,
    // core side
    input wire logic [3:0] core_level,
    output logic [N-1:0] flag,
    output logic core_request,
    output logic [VEC_W-1:0] core_vector,
    output logic [IRQ_W-1:0] core_irq,
    output logic [PRIO_W-1:0] core_priority,
    output logic [ADDR_W-1:0] core_table_addr,
    output logic [ADDR_W-1:0] program_counter
);

    // ********************************
    // flag storage
    // ********************************
    logic [N-1:0] next_flag;
    logic [N-1:0] eligible;

    // RULE25 set beats clear
    // RULE27 only listed sources own storage
    assign next_flag = (flag & ~flag_clear) | source_event | flag_set_sw;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end

    // ********************************
    // eligibility per source
    // ********************************
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_elig
            // RULE26 three-bit field
            // RULE28 beats core level
            assign eligible[g] = flag[g] & enable[g] & !core_level[3] &
                (priority_level[g*PRIO_W +: PRIO_W] > core_level[2:0]);
        end
    endgenerate

    // ********************************
    // arbitration
    // ********************************
    logic found;
    logic [4:0] win_idx;
    logic [PRIO_W-1:0] win_prio;

    // RULE24 lower index wins ties
    always_comb begin
        found = 1'b0;
        win_idx = '0;
        win_prio = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (eligible[i] &&
                (!found || priority_level[i*PRIO_W +: PRIO_W] >= win_prio))
            begin
                found = 1'b1;
                win_idx = 5'(i);
                win_prio = priority_level[i*PRIO_W +: PRIO_W];
            end
        end
    end

    wire [VEC_W-1:0] win_vector = SRC_VECTOR[win_idx];
    wire [IRQ_W-1:0] win_irq = 8'(win_vector - 8'(VEC_TO_IRQ));
    // RULE23 entry address from table base
    wire [ADDR_W-1:0] win_addr = TABLE_BASE +
        ADDR_W'(win_vector) * ADDR_W'(VEC_STRIDE);

    // ********************************
    // core outputs
    // ********************************
    // RULE29 vector and level with request
    // RULE2 reset only clears, no arbitration
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core_request <= 1'b0;
            core_vector <= '0;
            core_irq <= '0;
            core_priority <= '0;
            core_table_addr <= '0;
        end else begin
            core_request <= found;
            core_vector <= found ? win_vector : '0;
            core_irq <= found ? win_irq : '0;
            core_priority <= found ? win_prio : '0;
            core_table_addr <= found ? win_addr : '0;
        end
    end

    // RULE1 fetch from zero after reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            program_counter <= RESET_ADDR;
        end else begin
            program_counter <= RESET_ADDR;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    flag_sticky_a: assert property (
        flag[0] && !flag_clear[0] |=> flag[0]) // RULE25
        else $error("flag lost without clear");
    event_sets_a: assert property (
        source_event[3] |=> flag[3]) // RULE25
        else $error("event did not set flag");
    request_cause_a: assert property (
        |eligible |=> core_request) // RULE28
        else $error("eligible source not requested");
    no_spurious_a: assert property (
        !(|eligible) |=> !core_request) // RULE28
        else $error("request without eligible source");
    level_above_a: assert property (
        core_request |-> core_priority > $past(core_level[2:0])) // RULE28
        else $error("request priority not above core level");
    vec_zero_a: assert property (
        eligible[0] && priority_level[2:0] == 3'h7 |=>
        core_vector == 8'h08 && core_table_addr == 24'h000014) // RULE4
        else $error("source zero vector wrong");
    irq_offset_a: assert property (
        core_request |-> core_irq == core_vector - 8'h08) // RULE29
        else $error("irq number mismatch");
    addr_match_a: assert property (
        core_request |->
        core_table_addr == 24'h000004 + {15'h0, core_vector, 1'b0}) // RULE23
        else $error("table address mismatch");
    pc_zero_a: assert property (
        program_counter == 24'h000000) // RULE1
        else $error("program counter not zero");
    tie_low_a: assert property ( // RULE24
        eligible[0] && eligible[1] &&
        priority_level[2:0] == priority_level[5:3] |=>
        core_vector != 8'h09)
        else $error("tie not to lower vector");
    set_wins_a: assert property ( // RULE25
        source_event[0] && flag_clear[0] |=> flag[0])
        else $error("clear beat a same-cycle event");
    sw_set_a: assert property ( // RULE25
        flag_set_sw[1] |=> flag[1])
        else $error("software set did not set flag");
    clear_works_a: assert property ( // RULE25
        flag_clear[2] && !source_event[2] && !flag_set_sw[2] |=> !flag[2])
        else $error("flag survived its clear");
    mask_all_a: assert property ( // RULE28
        core_level[3] |=> !core_request)
        else $error("request while core level masks all");
    idle_zero_a: assert property ( // RULE29
        !core_request |-> core_vector == 8'h00 &&
        core_table_addr == 24'h000000)
        else $error("winner info shown without request");

    // ********************************
    // per-source map checks
    // ********************************
    // lone eligible source, so the winner is fixed by the map alone
    capture_map_a: assert property ( // RULE5
        eligible == (N'(1) << 1) |=>
        core_vector == 8'h09 && core_irq == 8'h01 &&
        core_table_addr == 24'h000016)
        else $error("capture unit one mapping wrong");

    compare_map_a: assert property ( // RULE6
        eligible == (N'(1) << 2) |=>
        core_vector == 8'h0A && core_irq == 8'h02 &&
        core_table_addr == 24'h000018)
        else $error("compare unit one mapping wrong");

    dma_zero_map_a: assert property ( // RULE7
        eligible == (N'(1) << 3) |=>
        core_vector == 8'h0C && core_irq == 8'h04 &&
        core_table_addr == 24'h00001C)
        else $error("dma channel zero mapping wrong");

    serial_map_a: assert property ( // RULE8
        eligible == (N'(1) << 4) |=>
        core_vector == 8'h12 && core_irq == 8'h0A &&
        core_table_addr == 24'h000028)
        else $error("serial one done mapping wrong");

    uart_rx_map_a: assert property ( // RULE9
        eligible == (N'(1) << 5) |=>
        core_vector == 8'h13 && core_irq == 8'h0B &&
        core_table_addr == 24'h00002A)
        else $error("uart one receive mapping wrong");

    converter_map_a: assert property ( // RULE10
        eligible == (N'(1) << 6) |=>
        core_vector == 8'h15 && core_irq == 8'h0D &&
        core_table_addr == 24'h00002E)
        else $error("converter done mapping wrong");

    i2c_one_map_a: assert property ( // RULE11
        eligible == (N'(1) << 7) |=>
        core_vector == 8'h18 && core_irq == 8'h10 &&
        core_table_addr == 24'h000034)
        else $error("i2c one target mapping wrong");

    change_map_a: assert property ( // RULE12
        eligible == (N'(1) << 8) |=>
        core_vector == 8'h1B && core_irq == 8'h13 &&
        core_table_addr == 24'h00003A)
        else $error("input change mapping wrong");

    dma_two_map_a: assert property ( // RULE13
        eligible == (N'(1) << 9) |=>
        core_vector == 8'h20 && core_irq == 8'h18 &&
        core_table_addr == 24'h000044)
        else $error("dma channel two mapping wrong");

    uart_tx_map_a: assert property ( // RULE14
        eligible == (N'(1) << 10) |=>
        core_vector == 8'h27 && core_irq == 8'h1F &&
        core_table_addr == 24'h000052)
        else $error("uart two transmit mapping wrong");

    can_rx_map_a: assert property ( // RULE15
        eligible == (N'(1) << 11) |=>
        core_vector == 8'h2A && core_irq == 8'h22 &&
        core_table_addr == 24'h000058)
        else $error("can receive ready mapping wrong");

    i2c_two_map_a: assert property ( // RULE16
        eligible == (N'(1) << 12) |=>
        core_vector == 8'h39 && core_irq == 8'h31 &&
        core_table_addr == 24'h000076)
        else $error("i2c two target mapping wrong");

    pwm_match_map_a: assert property ( // RULE17
        eligible == (N'(1) << 13) |=>
        core_vector == 8'h41 && core_irq == 8'h39 &&
        core_table_addr == 24'h000086)
        else $error("pwm special match mapping wrong");

    uart_err_map_a: assert property ( // RULE18
        eligible == (N'(1) << 14) |=>
        core_vector == 8'h49 && core_irq == 8'h41 &&
        core_table_addr == 24'h000096)
        else $error("uart one error mapping wrong");

    crc_map_a: assert property ( // RULE19
        eligible == (N'(1) << 15) |=>
        core_vector == 8'h4B && core_irq == 8'h43 &&
        core_table_addr == 24'h00009A)
        else $error("crc generator mapping wrong");

    charge_map_a: assert property ( // RULE20
        eligible == (N'(1) << 16) |=>
        core_vector == 8'h55 && core_irq == 8'h4D &&
        core_table_addr == 24'h0000AE)
        else $error("charge time unit mapping wrong");

    pwm_gen_map_a: assert property ( // RULE21
        eligible == (N'(1) << 17) |=>
        core_vector == 8'h66 && core_irq == 8'h5E &&
        core_table_addr == 24'h0000D0)
        else $error("pwm generator one mapping wrong");

    watchdog_map_a: assert property ( // RULE22
        eligible == (N'(1) << 18) |=>
        core_vector == 8'h9A && core_irq == 8'h92 &&
        core_table_addr == 24'h000138)
        else $error("trigger watchdog mapping wrong");

    pend_c: cover property (core_request);
    tie_c: cover property (eligible[0] && eligible[1]);
    masked_c: cover property (|(flag & enable) && !(|eligible));
    clear_c: cover property (flag[0] ##1 !flag[0]);
    set_clear_c: cover property (source_event[0] && flag_clear[0]);

endmodule
`default_nettype wire

// >>> testbench/core_model.sv
/* processor core model: holds the current level, counts taken requests.
   assumes the same clock and reset as the vector map. */
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // system
    input wire logic clock,
    input wire logic reset_n,
    // vector map side
    input wire logic core_request,
    input wire logic [3:0] want_level,
    output logic [3:0] core_level,
    output var int taken
);
    logic last_request;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            last_request <= 1'b0;
            taken <= 0;
        end else begin
            last_request <= core_request;
            if (core_request && !last_request) begin
                taken <= taken + 1;
            end
        end
    end
    // unused entries left to firmware; model never vectors there
    // level only moves when the bench says so, not on acceptance
    assign core_level = want_level;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
/* self-checking bench for the vector map: reset check, row loop, then
   tie, masking and mid-run reset. assumes core_model beside it. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vector_map_pkg::*;
    localparam int N = NUM_SOURCES;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [N-1:0] source_event = '0, flag_clear = '0, flag_set_sw = '0;
    logic [N-1:0] enable = '1, flag;
    logic [N*PRIO_W-1:0] priority_level = '1;
    logic [3:0] core_level, want_level = 4'h0;
    logic core_request;
    logic [VEC_W-1:0] core_vector;
    logic [IRQ_W-1:0] core_irq;
    logic [PRIO_W-1:0] core_priority;
    logic [ADDR_W-1:0] core_table_addr, program_counter;
    int mismatches = 0, n_checks = 0, taken, v, p;
    int vec_row [N] = '{8, 9, 10, 12, 18, 19, 21, 24, 27, 32, 39, 42,
        57, 65, 73, 75, 85, 102, 154};
    always #10 clock = ~clock;
    interrupt_vector_map i_dut (.clock(clock), .reset_n(reset_n),
        .source_event(source_event), .flag_clear(flag_clear),
        .flag_set_sw(flag_set_sw), .enable(enable),
        .priority_level(priority_level), .core_level(core_level),
        .flag(flag), .core_request(core_request),
        .core_vector(core_vector), .core_irq(core_irq),
        .core_priority(core_priority), .core_table_addr(core_table_addr),
        .program_counter(program_counter));
    core_model i_core (.clock(clock), .reset_n(reset_n),
        .core_request(core_request), .want_level(want_level),
        .core_level(core_level), .taken(taken));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %0t seen %0h want %0h", $time, seen, want);
        end
    endtask
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    task automatic fire(input logic [N-1:0] m);
        source_event = m;
        tick;
        source_event = '0;
        tick;
    endtask
    task automatic clr(input logic [N-1:0] m);
        flag_clear = m;
        tick;
        flag_clear = '0;
        tick;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge clock);
        #1;
        reset_n = 1'b1;
        check(program_counter, 32'h0);
        check(core_request, 32'h0);
        tick;
        for (int i = 0; i < N; i++) begin
            v = vec_row[i];
            p = i % 7 + 1;
            priority_level[3*i+:3] = p[2:0];
            fire(N'(1) << i);
            check(core_vector, v);
            check(core_irq, v - 8);
            check(core_table_addr, 4 + 2 * v);
            check(core_priority, p);
            clr(N'(1) << i);
            check(flag[i], 32'h0);
            check(core_request, 32'h0);
        end
        $display("row test done");
        priority_level = '1;
        fire(N'(40));
        // lower vector wins an equal level
        check(core_vector, 32'h0C);
        priority_level[15+:3] = 3'h7;
        priority_level[9+:3] = 3'h3;
        tick;
        tick;
        check(core_vector, 32'h13);
        clr(N'(40));
        $display("tie test done");
        want_level = 4'h7;
        fire(N'(1));
        check(core_request, 32'h0);
        want_level = 4'h6;
        tick;
        tick;
        check(core_request, 32'h1);
        want_level = 4'h8;
        tick;
        tick;
        check(core_request, 32'h0);
        enable = '0;
        want_level = 4'h0;
        tick;
        tick;
        check(core_request, 32'h0);
        check(taken > 0, 32'h1);
        enable = '1;
        reset_n = 1'b0;
        tick;
        check(flag, 32'h0);
        reset_n = 1'b1;
        tick;
        tick;
        check(core_request, 32'h0);
        flag_set_sw = N'(2);
        tick;
        flag_set_sw = '0;
        check(flag[1], 32'h1);
        flag_clear = N'(2);
        source_event = N'(2);
        tick;
        flag_clear = '0;
        source_event = '0;
        check(flag[1], 32'h1);
        clr(N'(2));
        check(flag[1], 32'h0);
        $display("mask and reset test done");
        test_done;
    end
endmodule
`default_nettype wire
